// *** pad_mux.sv ***
// pull-up disable, clock-out select and shared port pad muxing, apb slave
// assumes all clock sources are glitch-tolerant where muxed; one clock pclk
//
// Overview of operation
// - set pull-up bit disables group pull-ups
// - bits 14,13,12: fault a3, can rx, strap
// - bits 11,10,9: reset, irq pins, boot
// - bit 8 modulator b faults, 7 a0-2
// - bit 5 strobes, bit 3 jtag pins
// - reserved bits read zero, ignore writes
// - tristate bit floats clock pin, resets one
// - select codes route five documented clocks
// - other low codes route factory test clocks
// - bit 9: b7 address or oscillator
// - bit 8: b6 address or clock two
// - bit 7: b5 address or system clock
// - bit 6: b4 address or prescaler clock
// - port b gpio beats address/clock choice
// - port c resets to peripheral, decoder
// - gpio mode: direction bit sets output
// - select one spi, zero timer with enable
// - each port c pin controlled independently
// - select bits reset zero, map spi signals
//
// The implementer's own choice: the APB register port.
`timescale 1ns/10ps
`include "pad_mux_defs.svh"

module pad_mux
	import pad_mux_pkg::*;
#(
	parameter int SRC_W = 5
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire apb_req_s apb_req,
	output apb_rsp_s apb_rsp,
	// pull-up disables
	output logic modulator_a_fault3_pullup_off,
	output logic can_rx_pullup_off,
	output logic ext_mem_mode_strap_pullup_off,
	output logic reset_pin_pullup_off,
	output logic ext_irq_pins_pullup_off,
	output logic boot_strap_pullup_off,
	output logic modulator_b_faults_pullup_off,
	output logic modulator_a_fault012_pullup_off,
	output logic strobes_pullup_off,
	output logic jtag_pullup_off,
	// clock-out pin
	input wire logic [31:0] clock_sources,
	output logic clock_out_pin,
	output logic clock_out_pin_oe,
	// port b upper four pins
	input wire logic [3:0] port_b_peripheral_enable,
	input wire logic [3:0] port_b_gpio_out,
	input wire logic [3:0] address_hi,
	input wire logic [3:0] port_b_alt_clocks,
	output logic [3:0] port_b_pad_out,
	// port c shared pins
	input wire logic [3:0] port_c_gpio_out,
	input wire logic [3:0] timer_out,
	input wire pad4_s spi_pads,
	output pad4_s port_c_pad,
	output logic [3:0] port_c_to_timer,
	output logic [3:0] port_c_to_spi,
	input wire logic [3:0] port_c_pad_in
);

	initial begin
		if (SRC_W != 5) $error("pad_mux: SRC_W must be 5");
	end

	// ==========================================================
	// apb decode
	logic [15:0] pud_q;
	logic [15:0] cko_q;
	logic [15:0] pcs_q;
	logic [15:0] pcc_q;

	wire logic access = apb_req.psel && apb_req.penable;
	wire logic wr = access && apb_req.pwrite && clk_en;
	wire logic hit_pud = apb_req.paddr == `PUD_OFFSET;
	wire logic hit_cko = apb_req.paddr == `CKO_OFFSET;
	wire logic hit_pcs = apb_req.paddr == `PCS_OFFSET;
	wire logic hit_pcc = apb_req.paddr == `PCC_OFFSET;
	wire logic hit_any = hit_pud | hit_cko | hit_pcs | hit_pcc;
	wire logic [15:0] wdata = apb_req.pwdata[15:0];

	// masked write keeps reserved bits at zero
	function automatic logic [15:0] masked(input logic [15:0] d, input logic [15:0] m);
		return d & m;
	endfunction

	// ==========================================================
	// registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pud_q <= `PUD_RESET;
			cko_q <= `CKO_RESET;
			pcs_q <= `PCS_RESET;
			pcc_q <= `PCC_RESET;
		end else if (wr) begin
			if (hit_pud) pud_q <= masked(wdata, `PUD_WMASK);
			if (hit_cko) cko_q <= masked(wdata, `CKO_WMASK);
			if (hit_pcs) pcs_q <= masked(wdata, `PCS_WMASK);
			if (hit_pcc) pcc_q <= masked(wdata, `PCC_WMASK);
		end
	end

	// read data combinational; answer in the access cycle with zero wait
	logic [31:0] rdata;
	assign rdata = hit_pud ? {16'h0000, pud_q} :
		hit_cko ? {16'h0000, cko_q} :
		hit_pcs ? {16'h0000, pcs_q} :
		hit_pcc ? {16'h0000, pcc_q} : 32'h0000_0000;

	assign apb_rsp.pready = 1'b1;
	assign apb_rsp.pslverr = access && !hit_any;
	assign apb_rsp.prdata = rdata;

	// ==========================================================
	// pull-up disables
	assign modulator_a_fault3_pullup_off = pud_q[`PUD_MODA_F3];
	assign can_rx_pullup_off = pud_q[`PUD_CAN_RX];
	assign ext_mem_mode_strap_pullup_off = pud_q[`PUD_MEM_MODE];
	assign reset_pin_pullup_off = pud_q[`PUD_RESET_PIN];
	assign ext_irq_pins_pullup_off = pud_q[`PUD_IRQ];
	assign boot_strap_pullup_off = pud_q[`PUD_BOOT];
	assign modulator_b_faults_pullup_off = pud_q[`PUD_MODB_F];
	assign modulator_a_fault012_pullup_off = pud_q[`PUD_MODA_F012];
	assign strobes_pullup_off = pud_q[`PUD_STROBES];
	assign jtag_pullup_off = pud_q[`PUD_JTAG];

	// ==========================================================
	// clock out: combinational mux, clocks cannot pass a flop
	wire logic [SRC_W-1:0] clock_out_source = cko_q[`CKO_SRC_LSB +: SRC_W];
	wire logic clock_out_tristate = cko_q[`CKO_TRI_BIT];
	// sources indexed by code; codes 0x12+ also select their clock_sources bit
	assign clock_out_pin = clock_out_tristate ? 1'b0 : clock_sources[clock_out_source];
	assign clock_out_pin_oe = !clock_out_tristate;

	// ==========================================================
	// port b upper pins
	wire logic [3:0] portb_alt_select = cko_q[`CKO_ALT_LSB +: 4];
	genvar i;
	generate
		for (i = 0; i < 4; i++) begin : g_pb
			// index 3..0 = b7..b4
			wire logic periph = portb_alt_select[i] ? port_b_alt_clocks[i] : address_hi[i];
			assign port_b_pad_out[i] = port_b_peripheral_enable[i] ? periph : port_b_gpio_out[i];
		end
	endgenerate

	// ==========================================================
	// port c shared pins
	wire logic [3:0] port_c_peripheral_enable = pcc_q[`PCC_PER_LSB +: 4];
	wire logic [3:0] port_c_direction = pcc_q[`PCC_DIR_LSB +: 4];
	wire logic [3:0] timer_output_enable = pcc_q[`PCC_TOE_LSB +: 4];
	wire logic [3:0] port_c_peripheral_select = pcs_q[3:0];
	logic [3:0] pc_in_q;
	logic [3:0] pc_meta_q;

	// pad inputs come from outside: two flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pc_in_q <= 4'h0;
		end else if (clk_en) begin
			pc_in_q <= pc_meta_q;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) pc_meta_q <= 4'h0;
		else if (clk_en) pc_meta_q <= port_c_pad_in;
	end

	generate
		for (i = 0; i < 4; i++) begin : g_pc
			wire logic per = port_c_peripheral_enable[i];
			wire logic spi = port_c_peripheral_select[i];
			assign port_c_pad.out[i] = !per ? port_c_gpio_out[i] :
				spi ? spi_pads.out[i] : timer_out[i];
			assign port_c_pad.oe[i] = !per ? port_c_direction[i] :
				spi ? spi_pads.oe[i] : timer_output_enable[i];
			assign port_c_to_timer[i] = per && !spi && pc_in_q[i];
			assign port_c_to_spi[i] = per && spi && pc_in_q[i];
		end
	endgenerate

endmodule // pad_mux

// *** pad_mux_assertions.sv ***
// checker for pad_mux: pull-up bits, clock-out enable, port b priority
// bound to pad_mux; sees only its ports, one clock domain
`timescale 1ns/10ps
`include "pad_mux_defs.svh"
module pad_mux_assertions
	import pad_mux_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire apb_req_s apb_req,
	input wire apb_rsp_s apb_rsp,
	input wire logic modulator_a_fault3_pullup_off,
	input wire logic reset_pin_pullup_off,
	input wire logic modulator_b_faults_pullup_off,
	input wire logic jtag_pullup_off,
	input wire logic clock_out_pin,
	input wire logic clock_out_pin_oe,
	input wire logic [3:0] port_b_peripheral_enable,
	input wire logic [3:0] port_b_gpio_out,
	input wire logic [3:0] port_b_pad_out
);
	// ==========
	// write and read strobes
	wire acc = apb_req.psel & apb_req.penable & clk_en;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence pud_wr_s; acc && apb_req.pwrite && apb_req.paddr == `PUD_OFFSET; endsequence
	sequence cko_wr_s; acc && apb_req.pwrite && apb_req.paddr == `CKO_OFFSET; endsequence
	sequence pud_rd_s; acc && !apb_req.pwrite && apb_req.paddr == `PUD_OFFSET; endsequence
	// ==========
	// properties
	fault3_pu_a: assert property (
		pud_wr_s |=> modulator_a_fault3_pullup_off == $past(apb_req.pwdata[14])) else $error("bit 14");
	reset_pu_a: assert property (
		pud_wr_s |=> reset_pin_pullup_off == $past(apb_req.pwdata[11])) else $error("bit 11");
	modb_pu_a: assert property (
		pud_wr_s |=> modulator_b_faults_pullup_off == $past(apb_req.pwdata[8])) else $error("bit 8");
	jtag_pu_a: assert property (
		pud_wr_s |=> jtag_pullup_off == $past(apb_req.pwdata[3])) else $error("bit 3");
	cko_tri_a: assert property (
		cko_wr_s |=> clock_out_pin_oe != $past(apb_req.pwdata[5])) else $error("tristate bit");
	tri_low_a: assert property (
		!clock_out_pin_oe |-> !clock_out_pin) else $error("floating pin driven");
	gpio_wins_a: assert property (
		((port_b_pad_out ^ port_b_gpio_out) & ~port_b_peripheral_enable) == 4'h0)
		else $error("gpio priority lost");
	rsvd_zero_a: assert property (
		pud_rd_s |-> (apb_rsp.prdata & ~32'h00007fa8) == 32'h0) else $error("reserved bits set");
endmodule // pad_mux_assertions

bind pad_mux pad_mux_assertions u_chk (.*);

// *** pad_mux_defs.svh ***
// register offsets, field positions, reset values for the pad mux block
// assumes inclusion from the package, the design module, the checker and the bench
`ifndef PAD_MUX_DEFS_SVH
`define PAD_MUX_DEFS_SVH

// byte addresses on the 32-bit apb
`define PUD_OFFSET 12'h008
`define CKO_OFFSET 12'h00c
`define PCS_OFFSET 12'h010
`define PCC_OFFSET 12'h014

// pull-up disable fields
`define PUD_WMASK 16'h7fa8
`define PUD_RESET 16'h0000
`define PUD_MODA_F3 14
`define PUD_CAN_RX 13
`define PUD_MEM_MODE 12
`define PUD_RESET_PIN 11
`define PUD_IRQ 10
`define PUD_BOOT 9
`define PUD_MODB_F 8
`define PUD_MODA_F012 7
`define PUD_STROBES 5
`define PUD_JTAG 3

// clock-out select fields
`define CKO_WMASK 16'h03ff
`define CKO_RESET 16'h0020
`define CKO_ALT_LSB 6
`define CKO_TRI_BIT 5
`define CKO_SRC_LSB 0

// source codes
`define SRC_SYS 5'h00
`define SRC_OSC 5'h07
`define SRC_GEN 5'h08
`define SRC_CONV_A 5'h10
`define SRC_CONV_B 5'h11

// port c select and control
`define PCS_WMASK 16'h000f
`define PCS_RESET 16'h0000
`define PCC_WMASK 16'h0fff
`define PCC_RESET 16'h000f
`define PCC_PER_LSB 0
`define PCC_DIR_LSB 4
`define PCC_TOE_LSB 8

`endif

// *** pad_mux_pkg.sv ***
// types shared by the pad mux block
// assumes pad_mux_defs.svh is on the include path
package pad_mux_pkg;
	`include "pad_mux_defs.svh"

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} apb_req_s;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} apb_rsp_s;

	typedef struct packed {
		logic [3:0] out;
		logic [3:0] oe;
	} pad4_s;
endpackage

// *** pad_mux_test.sv ***
// self-checking bench for pad_mux, registers over apb
// assumes pad_mux_pkg compiled first; single clock, bench drives all pins
`timescale 1ns/10ps
`include "pad_mux_defs.svh"
module pad_mux_test;
	import pad_mux_pkg::*;
	logic pclk = 0;
	logic ce = 1'b1;
	logic presetn = 0;
	apb_req_s req = '0;
	apb_rsp_s rsp;
	logic [31:0] src = '0;
	logic [31:0] r;
	logic e;
	logic [3:0] bpe = 4'hf;
	logic [3:0] bgo = 4'h0;
	pad4_s spi = '{4'h3, 4'hf};
	pad4_s cpad;
	wire [9:0] pu;
	wire cko;
	wire cko_oe;
	wire [3:0] bpad;
	int n_mismatch = 0;
	int comparisons = 0;
	always #2 pclk = ~pclk;
	pad_mux u_dut (.pclk(pclk), .presetn(presetn), .clk_en(ce), .apb_req(req), .apb_rsp(rsp),
		.modulator_a_fault3_pullup_off(pu[9]), .can_rx_pullup_off(pu[8]),
		.ext_mem_mode_strap_pullup_off(pu[7]), .reset_pin_pullup_off(pu[6]),
		.ext_irq_pins_pullup_off(pu[5]), .boot_strap_pullup_off(pu[4]),
		.modulator_b_faults_pullup_off(pu[3]), .modulator_a_fault012_pullup_off(pu[2]),
		.strobes_pullup_off(pu[1]), .jtag_pullup_off(pu[0]), .clock_sources(src),
		.clock_out_pin(cko), .clock_out_pin_oe(cko_oe), .port_b_peripheral_enable(bpe),
		.port_b_gpio_out(bgo), .address_hi(4'h5), .port_b_alt_clocks(4'ha), .port_b_pad_out(bpad),
		.port_c_gpio_out(4'h6), .timer_out(4'h9), .spi_pads(spi), .port_c_pad(cpad),
		.port_c_to_timer(), .port_c_to_spi(), .port_c_pad_in(4'h0));
	task chk(input logic [31:0] s, input logic [31:0] x);
		comparisons++;
		if (s !== x) begin
			n_mismatch++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, x);
		end
	endtask
	task wrap_up;
		$display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// ==========
	// apb master: setup, access until pready
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge pclk);
		req.penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (rsp.pready !== 1'b1 && i < 16);
		if (rsp.pready !== 1'b1) begin
			n_mismatch++;
			wrap_up;
		end
		r = rsp.prdata;
		e = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		#1;
	endtask
	task clk_src(input logic [31:0] v);
		@(posedge pclk);
		src <= v;
		#1;
	endtask
	// ==========
	// scenarios
	task t_pud;
		logic [15:0] d;
		for (int b = 0; b < 16; b++) begin
			d = 16'h1 << b;
			apb(1'b1, `PUD_OFFSET, {16'h0, d});
			chk(pu, {d[14:7], d[5], d[3]});
			apb(1'b0, `PUD_OFFSET, 32'h0);
			chk(r, {16'h0, d & 16'h7fa8});
		end
		$display("t_pud end");
	endtask
	// writes with the clock enable low must be dropped
	task t_hold;
		@(posedge pclk);
		ce <= 1'b0;
		apb(1'b1, `PUD_OFFSET, 32'hffff);
		chk(pu, 10'h0);
		@(posedge pclk);
		ce <= 1'b1;
		$display("t_hold end");
	endtask
	task t_cko;
		for (int c = 0; c < 18; c++) begin
			apb(1'b1, `CKO_OFFSET, 32'(c));
			clk_src(32'h1 << c);
			chk({cko_oe, cko}, 2'h3);
			clk_src(~(32'h1 << c));
			chk(cko, 1'b0);
		end
		apb(1'b1, `CKO_OFFSET, 32'hffff_ffe7);
		chk({cko_oe, cko}, 2'h0);
		apb(1'b0, `CKO_OFFSET, 32'h0);
		chk(r, 32'h3e7);
		$display("t_cko end");
	endtask
	task t_port;
		apb(1'b1, `CKO_OFFSET, 32'h3c0);
		chk(bpad, 4'ha);
		@(posedge pclk);
		bpe <= 4'h3;
		bgo <= 4'h4;
		apb(1'b1, `CKO_OFFSET, 32'h0);
		chk(bpad, 4'h5);
		apb(1'b1, `PCC_OFFSET, 32'h50);
		chk({cpad.oe, cpad.out & cpad.oe}, 8'h54);
		apb(1'b1, `PCS_OFFSET, 32'ha);
		apb(1'b1, `PCC_OFFSET, 32'h10f);
		chk({cpad.oe, cpad.out & cpad.oe}, 8'hb3);
		apb(1'b0, 12'h040, 32'h0);
		chk({e, r}, 33'h1_0000_0000);
		$display("t_port end");
	endtask
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		#1;
		chk({pu, cko_oe, bpad, cpad.oe}, 19'h50);
		t_pud;
		t_hold;
		t_cko;
		t_port;
		wrap_up;
	end
endmodule // pad_mux_test
